/* File: design/uip_prioritizer.sv */
/*
 * uip_prioritizer: interrupt identification, enable gating and request
 * output of a serial port, reached over a classic Wishbone slave.
 * Assumes the datapath supplies one-cycle event pulses, the receive FIFO
 * fill level and a one-cycle pulse per elapsed character time, all
 * synchronous to clk_i.
 */
`timescale 1ns/10ps
`default_nettype none

module uip_prioritizer
	import uip_pkg::*;
(
	input  wire logic                 clk_i,          // 20 MHz system clock
	input  wire logic                 rst_i,          // sync reset, high
	input  wire logic                 wb_cyc_i,       // bus cycle
	input  wire logic                 wb_stb_i,       // strobe
	input  wire logic                 wb_we_i,        // write enable
	input  wire logic [uip_pkg::UIP_AW-1:0] wb_adr_i, // byte address
	input  wire logic [3:0]           wb_sel_i,       // byte lanes
	input  wire logic [uip_pkg::UIP_DW-1:0] wb_dat_i, // write data
	output logic [uip_pkg::UIP_DW-1:0] wb_dat_o,      // read data
	output logic                      wb_ack_o,       // acknowledge
	input  wire logic [3:0]           line_err_i,     // brk,frm,par,ovr pulses
	input  wire logic                 line_status_rd_i, // status reg read
	input  wire logic [3:0]           modem_delta_i,  // modem change pulses
	input  wire logic                 modem_status_rd_i, // modem reg read
	input  wire logic [4:0]           rx_level_i,     // rx characters held
	input  wire logic                 rx_char_i,      // char entered rx
	input  wire logic                 rx_buf_rd_i,    // rx buffer read
	input  wire logic                 char_tick_i,    // one char time pulse
	input  wire logic                 tx_empty_i,     // tx holding empty
	input  wire logic                 tx_hold_wr_i,   // tx holding write
	output logic                      fifo_enable_ctl_o, // FIFO mode
	output logic                      irq_line_o      // interrupt request
);

	////////////////////////////////////////////////////////////////////
	// helpers

	function automatic logic [4:0] trig_level(input logic [1:0] s);
		case (s)
			2'h0:    trig_level = UIP_TRG_1;
			2'h1:    trig_level = UIP_TRG_4;
			2'h2:    trig_level = UIP_TRG_8;
			default: trig_level = UIP_TRG_14;
		endcase
	endfunction : trig_level

	// vector: {line, rxav, tmo, thre, modem}
	function automatic logic [3:0] ident_code(input logic [4:0] p);
		if (p[4])
			ident_code = UIP_ID_LINE;
		else if (p[3])
			ident_code = UIP_ID_RXAV;
		else if (p[2])
			ident_code = UIP_ID_TMO;
		else if (p[1])
			ident_code = UIP_ID_THRE;
		else if (p[0])
			ident_code = UIP_ID_MODEM;
		else
			ident_code = UIP_ID_NONE;
	endfunction : ident_code

	////////////////////////////////////////////////////////////////////
	// state

	logic [7:0]  ier_r, ier_nxt;
	logic [7:0]  ctl_r, ctl_nxt;
	logic [3:0]  line_r, line_nxt;
	logic [3:0]  modem_r, modem_nxt;
	logic        thre_r, thre_nxt;
	logic        txe_d_r, txe_d_nxt;
	logic [2:0]  idle_r, idle_nxt;
	logic        tmo_r, tmo_nxt;
	logic        ack_r, ack_nxt;
	logic [31:0] dat_r, dat_nxt;
	logic        irq_r, irq_nxt;

	logic        fifo_on;
	logic        rx_avail;
	logic [4:0]  pend;
	logic [3:0]  code_now;
	logic [7:0]  ident_now;
	logic        req;
	logic        rd_ident;
	logic        thre_set;

	////////////////////////////////////////////////////////////////////
	// source conditions and priority

	always_comb begin
		fifo_on  = ctl_r[UIP_CTL_FIFO];
		// without FIFOs any held character counts as available
		if (fifo_on)
			rx_avail = rx_level_i >= trig_level(ctl_r[UIP_CTL_TRG +: 2]);
		else
			rx_avail = rx_level_i != 5'h00;
		// disabled classes vanish here only; flags keep running
		pend[4] = (|line_r) & ier_r[UIP_EN_LINE];
		pend[3] = rx_avail & ier_r[UIP_EN_RXAV];
		pend[2] = tmo_r & fifo_on & ier_r[UIP_EN_RXAV];
		pend[1] = thre_r & ier_r[UIP_EN_THRE];
		pend[0] = (|modem_r) & ier_r[UIP_EN_MODEM];
		code_now  = ident_code(pend);
		ident_now = {(fifo_on ? UIP_ID_FIFO : 2'h0), 2'h0, code_now};
	end

	////////////////////////////////////////////////////////////////////
	// bus decode

	always_comb begin
		req      = wb_cyc_i & wb_stb_i & ~ack_r;
		rd_ident = req & ~wb_we_i & (wb_adr_i == UIP_ADR_IDENT);
	end

	////////////////////////////////////////////////////////////////////
	// interrupt flags

	always_comb begin
		line_nxt  = line_r;
		modem_nxt = modem_r;
		thre_nxt  = thre_r;
		idle_nxt  = idle_r;
		tmo_nxt   = tmo_r;
		txe_d_nxt = tx_empty_i;
		// new edge of empty, or enabling while already empty
		thre_set  = (tx_empty_i & ~txe_d_r) |
			(tx_empty_i & ~ier_r[UIP_EN_THRE] & ier_nxt[UIP_EN_THRE]);

		// set wins over clear for every sticky flag
		if (line_status_rd_i)
			line_nxt = 4'h0;
		line_nxt = line_nxt | line_err_i;
		if (modem_status_rd_i)
			modem_nxt = 4'h0;
		modem_nxt = modem_nxt | modem_delta_i;

		// cleared by a holding write, or by an ident read only if it is what the reader sees
		if (tx_hold_wr_i | (rd_ident & code_now == UIP_ID_THRE))
			thre_nxt = 1'b0;
		if (thre_set)
			thre_nxt = 1'b1;

		// character time-out
		if (rx_char_i | rx_buf_rd_i | ~fifo_on | rx_level_i == 5'h00) begin
			idle_nxt = 3'h0;
		end else if (char_tick_i & idle_r != UIP_TMO_CHARS) begin
			idle_nxt = idle_r + 3'h1;
		end
		if (rx_buf_rd_i | ~fifo_on | rx_level_i == 5'h00)
			tmo_nxt = 1'b0;
		if (idle_nxt == UIP_TMO_CHARS)
			tmo_nxt = 1'b1;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			line_r  <= 4'h0;
			modem_r <= 4'h0;
			thre_r  <= 1'b0;
			// empty is the idle level: no false edge after reset
			txe_d_r <= 1'b1;
			idle_r  <= 3'h0;
			tmo_r   <= 1'b0;
		end else begin
			line_r  <= line_nxt;
			modem_r <= modem_nxt;
			thre_r  <= thre_nxt;
			txe_d_r <= txe_d_nxt;
			idle_r  <= idle_nxt;
			tmo_r   <= tmo_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////
	// registers and bus answer

	always_comb begin
		ier_nxt = ier_r;
		ctl_nxt = ctl_r;
		ack_nxt = req;
		dat_nxt = 32'h0000_0000;
		irq_nxt = |pend;
		if (req & wb_we_i & wb_sel_i[0]) begin
			case (wb_adr_i)
				UIP_ADR_IER: ier_nxt = wb_dat_i[7:0] & UIP_IER_MASK;
				UIP_ADR_CTL: ctl_nxt = wb_dat_i[7:0] & UIP_CTL_MASK;
				default:     ;
			endcase
		end
		if (req & ~wb_we_i) begin
			case (wb_adr_i)
				// snapshot taken once; flags may move meanwhile
				UIP_ADR_IDENT: dat_nxt = {24'h0, ident_now};
				UIP_ADR_IER:   dat_nxt = {24'h0, ier_r};
				UIP_ADR_CTL:   dat_nxt = {24'h0, ctl_r};
				// status: modem 10:7, tmo 6, thre 5, rx 4, line 3:0
				UIP_ADR_STAT:  dat_nxt = {21'h0, modem_r, tmo_r,
					thre_r, rx_avail, line_r};
				default:       dat_nxt = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ier_r <= UIP_IER_RST;
			ctl_r <= UIP_CTL_RST;
			ack_r <= 1'b0;
			dat_r <= 32'h0000_0000;
			irq_r <= 1'b0;
		end else begin
			ier_r <= ier_nxt;
			ctl_r <= ctl_nxt;
			ack_r <= ack_nxt;
			dat_r <= dat_nxt;
			irq_r <= irq_nxt;
		end
	end

	assign wb_ack_o          = ack_r;
	assign wb_dat_o          = dat_r;
	assign irq_line_o        = irq_r;
	assign fifo_enable_ctl_o = ctl_r[UIP_CTL_FIFO];

	////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	line_first_a: assert property (pend[4] |-> code_now == UIP_ID_LINE)
		else $error("line status not reported first");

	ident_snap_a: assert property (rd_ident |=> wb_ack_o &&
		wb_dat_o[7:0] == $past(ident_now))
		else $error("ident read not frozen value");

	event_kept_a: assert property ((rd_ident &&
		line_err_i != 4'h0) |=> line_r != 4'h0)
		else $error("event lost during ident read");

	bit0_pend_a: assert property (ident_now[0] == (pend == 5'h00))
		else $error("bit 0 disagrees with pending");

	tmo_bit3_a: assert property (!fifo_on |-> !ident_now[3])
		else $error("bit 3 set outside FIFO mode");

	fifo_bits_a: assert property ((rd_ident && fifo_on) |=>
		wb_dat_o[7:4] == 4'hC)
		else $error("ident upper bits wrong");

	ier_high_a: assert property ((req && !wb_we_i &&
		wb_adr_i == UIP_ADR_IER) |=> wb_dat_o[7:4] == 4'h0)
		else $error("enable upper bits not zero");

	thre_clr_a: assert property ((tx_hold_wr_i &&
		!thre_set) |=> !thre_r)
		else $error("tx empty not cleared on write");

	irq_track_a: assert property ((pend != 5'h00) |=>
		irq_line_o ##1 (irq_line_o || $past(pend) == 5'h00))
		else $error("request not following pending");

	tmo_set_a: assert property ((fifo_on &&
		rx_level_i != 5'h00 && !rx_char_i && !rx_buf_rd_i &&
		char_tick_i && idle_r == 3'h3) |=> tmo_r)
		else $error("time-out not raised after four chars");

	rst_state_a: assert property ($past(rst_i) |->
		ier_r == 8'h00 && !irq_line_o)
		else $error("state not cleared by reset");

	line_clr_a: assert property ((line_status_rd_i &&
		line_err_i == 4'h0) |=> line_r == 4'h0)
		else $error("line flags not cleared by status read");

	line_only_a: assert property ($rose(line_r != 4'h0) |->
		$past(line_err_i) != 4'h0)
		else $error("line flag raised without line error");

	rx_code_a: assert property ((pend[3] && !pend[4]) |->
		code_now == UIP_ID_RXAV)
		else $error("rx data code wrong");

	tmo_code_a: assert property ((pend[2] &&
		pend[4:3] == 2'h0) |-> code_now == UIP_ID_TMO)
		else $error("time-out code wrong");

	thre_code_a: assert property ((pend[1] &&
		pend[4:2] == 3'h0) |-> code_now == UIP_ID_THRE)
		else $error("tx empty code wrong");

	modem_code_a: assert property ((pend == 5'h01) |->
		code_now == UIP_ID_MODEM)
		else $error("modem code wrong");

	modem_clr_a: assert property ((modem_status_rd_i &&
		modem_delta_i == 4'h0) |=> modem_r == 4'h0)
		else $error("modem flags not cleared by read");

	modem_set_a: assert property ((modem_delta_i != 4'h0) |=>
		modem_r != 4'h0)
		else $error("modem change not latched");

	tmo_clr_a: assert property (rx_buf_rd_i |=> !tmo_r)
		else $error("time-out not cleared by rx read");

	zero_bits_a: assert property (ident_now[5:4] == 2'h0)
		else $error("ident bits 5 and 4 not zero");

	fifo_off_a: assert property (!fifo_on |->
		ident_now[7:6] == 2'h0)
		else $error("ident bits 7 and 6 set without FIFO");

	irq_off_a: assert property ((pend == 5'h00) |=>
		!irq_line_o)
		else $error("request stays without pending class");

	ier_wr_a: assert property ((req && wb_we_i &&
		wb_sel_i[0] && wb_adr_i == UIP_ADR_IER) |=>
		ier_r == ($past(wb_dat_i[7:0]) & UIP_IER_MASK))
		else $error("enable write not masked");

	rx_gate_a: assert property (!ier_r[UIP_EN_RXAV] |->
		pend[3:2] == 2'h0)
		else $error("rx classes pass while disabled");

	thre_gate_a: assert property (!ier_r[UIP_EN_THRE] |->
		!pend[1])
		else $error("tx empty passes while disabled");

	line_gate_a: assert property (!ier_r[UIP_EN_LINE] |->
		!pend[4])
		else $error("line status passes while disabled");

	modem_gate_a: assert property (!ier_r[UIP_EN_MODEM] |->
		!pend[0])
		else $error("modem status passes while disabled");

	thre_read_a: assert property ((rd_ident && !thre_set &&
		code_now == UIP_ID_THRE) |=> !thre_r)
		else $error("tx empty not cleared by ident read");

	trig_top_a: assert property ((fifo_on &&
		ctl_r[UIP_CTL_TRG +: 2] == 2'h3 &&
		rx_level_i >= UIP_TRG_14) |-> rx_avail)
		else $error("top trigger level not reached");

	trig_low_a: assert property ((fifo_on &&
		ctl_r[UIP_CTL_TRG +: 2] == 2'h3 &&
		rx_level_i < UIP_TRG_14) |-> !rx_avail)
		else $error("rx available below trigger level");

endmodule : uip_prioritizer

`default_nettype wire

/* File: design/uip_pkg.sv */
/*
 * uip_pkg: register map, identification codes, field positions and
 * reset values for the serial port interrupt prioritizer.
 * Assumes a 32-bit classic Wishbone bus with byte addresses, one word per
 * register.
 */
package uip_pkg;

	localparam int unsigned UIP_AW = 4;
	localparam int unsigned UIP_DW = 32;

	// register byte offsets
	localparam logic [3:0] UIP_ADR_IDENT = 4'h0;
	localparam logic [3:0] UIP_ADR_IER   = 4'h4;
	localparam logic [3:0] UIP_ADR_CTL   = 4'h8;
	localparam logic [3:0] UIP_ADR_STAT  = 4'hC;

	// identification codes, bits 3..0; FIFO flags UIP_ID_FIFO, bits 7..6
	localparam logic [3:0] UIP_ID_NONE  = 4'h1;
	localparam logic [3:0] UIP_ID_LINE  = 4'h6;
	localparam logic [3:0] UIP_ID_RXAV  = 4'h4;
	localparam logic [3:0] UIP_ID_TMO   = 4'hC;
	localparam logic [3:0] UIP_ID_THRE  = 4'h2;
	localparam logic [3:0] UIP_ID_MODEM = 4'h0;
	localparam logic [1:0] UIP_ID_FIFO  = 2'h3;

	// enable register field positions
	localparam int unsigned UIP_EN_RXAV  = 0;
	localparam int unsigned UIP_EN_THRE  = 1;
	localparam int unsigned UIP_EN_LINE  = 2;
	localparam int unsigned UIP_EN_MODEM = 3;
	localparam logic [7:0]  UIP_IER_MASK = 8'h0F;
	localparam logic [7:0]  UIP_IER_RST  = 8'h00;

	// control register fields
	localparam int unsigned UIP_CTL_FIFO = 0;
	localparam int unsigned UIP_CTL_TRG  = 6;
	localparam logic [7:0]  UIP_CTL_MASK = 8'hC1;
	localparam logic [7:0]  UIP_CTL_RST  = 8'h00;

	// receive trigger levels in bytes
	localparam logic [4:0] UIP_TRG_1  = 5'h01;
	localparam logic [4:0] UIP_TRG_4  = 5'h04;
	localparam logic [4:0] UIP_TRG_8  = 5'h08;
	localparam logic [4:0] UIP_TRG_14 = 5'h0E;

	// character times of silence before a time-out
	localparam logic [2:0] UIP_TMO_CHARS = 3'h4;

endpackage : uip_pkg

/* File: test/uip_host_model.sv */
/*
 * uip_host_model: host processor doing single classic Wishbone accesses.
 * Assumes one go_i pulse per access, issued only while no access runs.
 */
`timescale 1ns/10ps
`default_nettype none

module uip_host_model (
	input  wire logic        clk_i,    // system clock
	input  wire logic        go_i,     // start one access
	input  wire logic        we_i,     // write access
	input  wire logic [3:0]  adr_i,    // byte address
	input  wire logic [31:0] wdat_i,   // write data
	input  wire logic [31:0] wb_dat_i, // slave read data
	input  wire logic        wb_ack_i, // slave acknowledge
	output logic             wb_cyc_o, // cycle
	output logic             wb_stb_o, // strobe
	output logic             wb_we_o,  // direction
	output logic [3:0]       wb_adr_o, // address
	output logic [3:0]       wb_sel_o, // byte lanes
	output logic [31:0]      wb_dat_o, // write data
	output logic [31:0]      rdat_o,   // captured read data
	output logic             done_o    // access finished
);
	initial begin
		{wb_cyc_o, wb_stb_o, wb_we_o, done_o} = 4'h0;
		{wb_adr_o, wb_sel_o, wb_dat_o, rdat_o} = '0;
	end

	// request held until ack is seen at a rising edge
	always @(posedge clk_i) begin
		done_o <= 1'b0;
		if (wb_stb_o && wb_ack_i) begin
			wb_cyc_o <= 1'b0;
			wb_stb_o <= 1'b0;
			rdat_o   <= wb_dat_i;
			wb_dat_o <= ~wb_dat_o; // released data never looks valid
			done_o   <= 1'b1;
		end else if (go_i && !wb_stb_o) begin
			wb_cyc_o <= 1'b1;
			wb_stb_o <= 1'b1;
			wb_we_o  <= we_i;
			wb_adr_o <= adr_i;
			wb_sel_o <= 4'hF;
			wb_dat_o <= wdat_i;
		end
	end
endmodule : uip_host_model

`default_nettype wire

/* File: test/testbench.sv */
/*
 * testbench: register and event sequences for the interrupt prioritizer.
 * Assumes the host model for bus cycles and a 20 MHz clock.
 */
`timescale 1ns/10ps
`default_nettype none

module testbench;
	import uip_pkg::*;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        go = 1'b0;
	logic        we = 1'b0;
	logic [3:0]  adr = 4'h0;
	logic [31:0] wd = '0;
	logic [13:0] pv = '0;
	logic [4:0]  rx_level = 5'h00;
	logic        tx_empty = 1'b0;
	logic        cyc, stb, wwe, ack, done, fifo_on, irq;
	logic [3:0]  wadr, sel;
	logic [31:0] wdo, wdi, rdat;
	int          err_total = 0;
	int          samples_checked = 0;
	logic [4:0]  lv[4] = '{UIP_TRG_1, UIP_TRG_4, UIP_TRG_8, UIP_TRG_14};

	always #25 clk = ~clk;

	uip_host_model i_uip_host_model (.clk_i(clk), .go_i(go), .we_i(we),
		.adr_i(adr), .wdat_i(wd), .wb_dat_i(wdi), .wb_ack_i(ack),
		.wb_cyc_o(cyc), .wb_stb_o(stb), .wb_we_o(wwe), .wb_adr_o(wadr),
		.wb_sel_o(sel), .wb_dat_o(wdo), .rdat_o(rdat), .done_o(done));

	uip_prioritizer i_uip_prioritizer (.clk_i(clk), .rst_i(rst),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(wwe), .wb_adr_i(wadr),
		.wb_sel_i(sel), .wb_dat_i(wdo), .wb_dat_o(wdi), .wb_ack_o(ack),
		.line_err_i(pv[3:0]), .line_status_rd_i(pv[4]),
		.modem_delta_i(pv[8:5]), .modem_status_rd_i(pv[9]),
		.rx_level_i(rx_level), .rx_char_i(pv[10]), .rx_buf_rd_i(pv[11]),
		.char_tick_i(pv[12]), .tx_empty_i(tx_empty),
		.tx_hold_wr_i(pv[13]), .fifo_enable_ctl_o(fifo_on),
		.irq_line_o(irq));

	task conclude;
		$display("compares %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : conclude

	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_total++;
			$display("unexpected %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	// one bus access; returns at a falling edge with outputs settled
	task acc(input logic w, input logic [3:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		go <= 1'b1;
		we <= w;
		adr <= a;
		wd <= d;
		@(posedge clk);
		go <= 1'b0;
		@(negedge clk);
		while (done !== 1'b1 && n < 20) begin
			@(negedge clk);
			n++;
		end
		if (n >= 20) err_total++;
	endtask : acc

	task rd(input logic [3:0] a, input logic [31:0] e);
		acc(1'b0, a, '0);
		chk("register", rdat, e);
	endtask : rd

	// one-cycle event pulse, then time for flags and request to follow
	task pulse(input logic [13:0] v);
		@(posedge clk);
		pv <= v;
		@(posedge clk);
		pv <= '0;
		repeat (3) @(negedge clk);
	endtask : pulse

	task levels(input logic [4:0] l, input logic t);
		@(posedge clk);
		rx_level <= l;
		tx_empty <= t;
	endtask : levels

	initial begin
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		rd(UIP_ADR_IDENT, 32'h01);
		rd(UIP_ADR_IER, 32'h00);
		acc(1'b1, UIP_ADR_IER, 32'hFF);
		rd(UIP_ADR_IER, 32'h0F);
		levels(5'h01, 1'b1);
		pulse(14'h0082);
		chk("irq", {31'h0, irq}, 32'h1);
		rd(UIP_ADR_IDENT, 32'h06);
		pulse(14'h0010);
		rd(UIP_ADR_IDENT, 32'h04);
		levels(5'h00, 1'b1);
		rd(UIP_ADR_IDENT, 32'h02);
		rd(UIP_ADR_IDENT, 32'h00);
		pulse(14'h0200);
		rd(UIP_ADR_IDENT, 32'h01);
		chk("irq", {31'h0, irq}, 32'h0);
		levels(5'h00, 1'b0);
		acc(1'b1, UIP_ADR_IER, 32'h00);
		pulse(14'h0008);
		rd(UIP_ADR_IDENT, 32'h01);
		chk("irq", {31'h0, irq}, 32'h0);
		acc(1'b1, UIP_ADR_IER, 32'h04);
		rd(UIP_ADR_IDENT, 32'h06);
		pulse(14'h0010);
		acc(1'b1, UIP_ADR_CTL, 32'h41);
		rd(UIP_ADR_IDENT, 32'hC1);
		acc(1'b1, UIP_ADR_IER, 32'h01);
		levels(5'h01, 1'b0);
		repeat (4) pulse(14'h1000);
		rd(UIP_ADR_IDENT, 32'hCC);
		chk("irq", {31'h0, irq}, 32'h1);
		pulse(14'h0800);
		rd(UIP_ADR_IDENT, 32'hC1);
		for (int t = 0; t < 4; t++) begin
			acc(1'b1, UIP_ADR_CTL, {24'h0, t[1:0], 6'h01});
			levels(lv[t], 1'b0);
			rd(UIP_ADR_IDENT, 32'hC4);
			levels(lv[t] - 5'h01, 1'b0);
			rd(UIP_ADR_IDENT, 32'hC1);
		end
		rd(UIP_ADR_CTL, 32'hC1);
		chk("fifo_on", {31'h0, fifo_on}, 32'h1);
		levels(5'h00, 1'b1);
		pulse(14'h0021);
		rd(UIP_ADR_STAT, 32'h0A1);
		rd(UIP_ADR_IDENT, 32'hC1);
		acc(1'b1, UIP_ADR_IER, 32'h02);
		chk("irq", {31'h0, irq}, 32'h1);
		pulse(14'h2000);
		chk("irq", {31'h0, irq}, 32'h0);
		acc(1'b1, UIP_ADR_IER, 32'h0C);
		rd(UIP_ADR_IDENT, 32'hC6);
		pulse(14'h0010);
		rd(UIP_ADR_IDENT, 32'hC0);
		pulse(14'h0200);
		// framing error lands on the edge that takes the ident read
		fork
			rd(UIP_ADR_IDENT, 32'hC1);
			begin
				@(posedge clk);
				pulse(14'h0004);
			end
		join
		rd(UIP_ADR_IDENT, 32'hC6);
		conclude();
	end

	// whole sequence needs well under 2000 cycles
	initial begin
		repeat (20000) @(posedge clk);
		err_total++;
		conclude();
	end
endmodule : testbench

`default_nettype wire
